//--- smpa_access.v
// Purpose: apb register bank for multicast port map table, phy
//          management access and strap view
// Assumes: apb slave, 32-bit data, straps are static pins
// Notes:   all outputs come from flip-flops
//
// Our own choice: the APB register port.
`timescale 1ns/1ns
`default_nettype none
`include "smpa_regs.vh"
module smpa_access (
   input wire core_clk, // 125 mhz clock
   input wire rst_b, // synchronous reset, active low
   input wire clkEn, // freezes all state when low
   input wire psel, // apb select
   input wire penable, // apb enable
   input wire pwrite, // apb direction
   input wire [7:0] paddr, // apb byte address
   input wire [31:0] pwdata, // apb write data
   output reg [31:0] prdata, // apb read data
   output reg pready, // apb ready
   output reg pslverr, // apb error
   input wire agingDisPin, // aging disable strap
   input wire autoNegPin, // autonegotiation strap
   input wire backPressPin, // back pressure strap
   input wire flowCtrlPin, // full duplex flow control strap
   input wire interPacketGapPin, // 92 bit time gap strap
   input wire trunkPin, // trunking strap
   input wire [1:0] rmiiSelPin, // port 24/25 rmii straps
   input wire bondRmiiPin, // bonding option
   input wire mdioIn, // mdio pin input
   output reg mdioOut, // mdio pin output
   output reg mdioOe, // mdio pin drive enable
   output reg mdc // management clock
);
   ////////////////////////////////////////////////////////////////////
   // state
   reg [`SMPA_MAP_W-1:0] mapTab [0:`SMPA_MDEPTH-1]; // port map table
   reg [31:0] mapIdx_q; // map and index word
   reg [2:0] cmd_q; // last command
   reg [`SMPA_MAP_W-1:0] resMap_q; // lookup result
   reg [2:0] result_q; // command result
   reg mcBusy_q; // table engine busy
   reg [2:0] mcOp_q; // pending engine op
   reg [15:0] phyData_q; // phy data field
   reg [4:0] phyReg_q; // phy register address
   reg [4:0] phyPort_q; // phy port number
   reg phyRd_q; // phy op, 1 = read
   reg phyBusy_q; // phy busy
   reg mdStart_q; // launch pulse to mdio engine
   reg [`SMPA_STRAP_W-1:0] strapMeta_q; // strap sync stage 1
   reg [`SMPA_STRAP_W-1:0] strap_q; // strap sync stage 2
   reg mdioMeta_q; // mdio sync stage 1
   reg mdioSync_q; // mdio sync stage 2
   wire mdDone; // frame complete
   wire [15:0] mdRd; // frame read data
   wire mdcW; // engine mdc
   wire mdioOutW; // engine mdio value
   wire mdioOeW; // engine mdio enable
   wire acc; // apb access phase
   wire wr; // write taken
   wire rd; // read taken
   integer i; // reset loop index

   assign acc = psel && penable;
   assign wr = acc && pwrite;
   assign rd = acc && !pwrite;

   ////////////////////////////////////////////////////////////////////
   // pin synchronisers, two flops each
   always @(posedge core_clk) begin
      if (!rst_b) begin
         strapMeta_q <= 9'h000;
         strap_q <= 9'h000;
         mdioMeta_q <= 1'b1;
         mdioSync_q <= 1'b1;
      end else if (clkEn) begin
         strapMeta_q <= {bondRmiiPin,
            rmiiSelPin,
            trunkPin,
            interPacketGapPin,
            flowCtrlPin,
            backPressPin,
            autoNegPin,
            agingDisPin};
         strap_q <= strapMeta_q;
         mdioMeta_q <= mdioIn;
         mdioSync_q <= mdioMeta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // mdio frame engine
   smpa_mdio uMdio (
      .core_clk(core_clk),
      .rst_b(rst_b),
      .clkEn(clkEn),
      .start(mdStart_q),
      .isRead(phyRd_q),
      .phyAddr(phyPort_q),
      .regAddr(phyReg_q),
      .wrData(phyData_q),
      .mdioInSync(mdioSync_q),
      .mdc(mdcW),
      .mdioOut(mdioOutW),
      .mdioOe(mdioOeW),
      .done(mdDone),
      .rdData(mdRd)
   );

   // register the pin drivers so outputs come straight from flops
   always @(posedge core_clk) begin
      if (!rst_b) begin
         mdc <= 1'b0;
         mdioOut <= 1'b1;
         mdioOe <= 1'b0;
      end else if (clkEn) begin
         mdc <= mdcW;
         mdioOut <= mdioOutW;
         mdioOe <= mdioOeW;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // multicast table engine: one cycle of work after a command
   always @(posedge core_clk) begin
      if (!rst_b) begin
         for (i = 0; i < `SMPA_MDEPTH; i = i + 1)
            mapTab[i] <= 26'h000_0000;
         mapIdx_q <= 32'h0000_0000;
         cmd_q <= 3'b000;
         resMap_q <= 26'h000_0000;
         result_q <= `SMPA_RES_OK;
         mcBusy_q <= 1'b0;
         mcOp_q <= 3'b000;
      end else if (clkEn) begin
         if (mcBusy_q) begin
            // bit n of the map is port n
            if (mcOp_q == `SMPA_CMD_CREATE)
               mapTab[mapIdx_q[`SMPA_MIDX_LSB+4:`SMPA_MIDX_LSB]]
                  <= mapIdx_q[`SMPA_MAP_W-1:0];
            else
               resMap_q <= mapTab[mapIdx_q[
                  `SMPA_MIDX_LSB+4:`SMPA_MIDX_LSB]];
            result_q <= `SMPA_RES_OK;
            mcBusy_q <= 1'b0;
         end else if (wr && paddr == `SMPA_ADDR_MAPIDX) begin
            mapIdx_q <= pwdata;
         end else if (wr && paddr == `SMPA_ADDR_CMD) begin
            cmd_q <= pwdata[2:0];
            // only create and search start the engine
            if (pwdata[2:0] == `SMPA_CMD_CREATE ||
                pwdata[2:0] == `SMPA_CMD_SEARCH) begin
               mcOp_q <= pwdata[2:0];
               mcBusy_q <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // phy management register
   always @(posedge core_clk) begin
      if (!rst_b) begin
         phyData_q <= 16'h0000;
         phyReg_q <= 5'h00;
         phyPort_q <= 5'h00;
         phyRd_q <= 1'b0;
         phyBusy_q <= 1'b0;
         mdStart_q <= 1'b0;
      end else if (clkEn) begin
         mdStart_q <= 1'b0;
         if (phyBusy_q) begin
            // writes while busy are ignored
            if (mdDone) begin
               phyBusy_q <= 1'b0;
               if (phyRd_q)
                  phyData_q <= mdRd;
            end
         end else if (wr && paddr == `SMPA_ADDR_PHY) begin
            phyData_q <= pwdata[`SMPA_PDATA_W-1:0];
            phyReg_q <= pwdata[`SMPA_PREG_LSB+4:`SMPA_PREG_LSB];
            phyPort_q <= pwdata[`SMPA_PPORT_LSB+4:`SMPA_PPORT_LSB];
            phyRd_q <= pwdata[`SMPA_POP_BIT];
            if (pwdata[`SMPA_PBUSY_BIT]) begin
               phyBusy_q <= 1'b1;
               mdStart_q <= 1'b1;
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////
   // apb answer: zero wait states, unmapped reads zero with error
   always @(posedge core_clk) begin
      if (!rst_b) begin
         prdata <= 32'h0000_0000;
         pready <= 1'b0;
         pslverr <= 1'b0;
      end else if (clkEn) begin
         pready <= psel && !penable;
         pslverr <= 1'b0;
         prdata <= 32'h0000_0000;
         if (psel && !penable) begin
            case (paddr)
               `SMPA_ADDR_PHY: prdata <= {4'h0, phyBusy_q, phyRd_q,
                  phyPort_q, phyReg_q, phyData_q};
               `SMPA_ADDR_STRAP: prdata <= {23'h00_0000, strap_q};
               `SMPA_ADDR_MAPIDX: prdata <= mapIdx_q;
               `SMPA_ADDR_CMD: prdata <= {29'h0000_0000, cmd_q};
               `SMPA_ADDR_RESMAP: prdata <= {6'h00, resMap_q};
               `SMPA_ADDR_STATE: prdata <= {28'h000_0000, mcBusy_q,
                  result_q};
               default: pslverr <= 1'b1;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

//--- smpa_regs.vh
// Purpose: register map, field layout and timing constants of the
//          multicast map / phy management access block
// Assumes: apb byte addresses, 32-bit data
// Notes:   definitions only
`ifndef SMPA_REGS_VH
`define SMPA_REGS_VH

// register byte addresses (printed index times four where printed)
`define SMPA_IDX_PHY 8'h0b
`define SMPA_IDX_STRAP 8'h0d
`define SMPA_ADDR_PHY 8'h2c
`define SMPA_ADDR_STRAP 8'h34
`define SMPA_ADDR_MAPIDX 8'h40
`define SMPA_ADDR_CMD 8'h44
`define SMPA_ADDR_RESMAP 8'h48
`define SMPA_ADDR_STATE 8'h4c

// multicast fields
`define SMPA_MAP_W 26
`define SMPA_MIDX_LSB 26
`define SMPA_MIDX_W 5
`define SMPA_MDEPTH 32
`define SMPA_CMD_CREATE 3'b100
`define SMPA_CMD_SEARCH 3'b101
`define SMPA_RES_OK 3'b000
`define SMPA_BUSY_BIT 3

// phy management fields and strap register width
`define SMPA_PDATA_W 16
`define SMPA_PREG_LSB 16
`define SMPA_PPORT_LSB 21
`define SMPA_POP_BIT 26
`define SMPA_PBUSY_BIT 27
`define SMPA_STRAP_W 9

// mdio timing: mdc half period 200 ns at 8 ns per cycle
`define SMPA_MDC_HALF_NS 200
`define SMPA_CLK_NS 8
`define SMPA_MDC_HALF_CYC (`SMPA_MDC_HALF_NS / `SMPA_CLK_NS)
`define SMPA_FRAME_BITS 7'd64
`define SMPA_PRE_BITS 6'd32
`define SMPA_TA_BIT 6'd46
`define SMPA_DATA_BIT 6'd48

`endif

//--- smpa_mdio.v
// Purpose: clause-22 mdio frame engine for the phy management register
// Assumes: one frame at a time, start only while idle
// Notes:   mdc derived from core_clk by a divider
`timescale 1ns/1ns
`default_nettype none
`include "smpa_regs.vh"
module smpa_mdio (
   input wire core_clk, // system clock
   input wire rst_b, // synchronous reset, active low
   input wire clkEn, // clock enable
   input wire start, // one-cycle launch pulse
   input wire isRead, // 1 = read frame
   input wire [4:0] phyAddr, // target phy
   input wire [4:0] regAddr, // target register
   input wire [15:0] wrData, // write data
   input wire mdioInSync, // synchronised mdio input
   output reg mdc, // management clock
   output reg mdioOut, // mdio drive value
   output reg mdioOe, // mdio drive enable
   output reg done, // one-cycle completion pulse
   output reg [15:0] rdData // captured read data
);
   reg [7:0] divCnt_q; // mdc half period counter
   reg active_q; // frame in progress
   reg [5:0] bitCnt_q; // bit index within frame
   reg [63:0] shift_q; // outgoing frame bits
   reg rd_q; // current frame is a read

   ////////////////////////////////////////////////////////////////////
   // frame sequencer: drive on mdc fall, sample on mdc rise
   always @(posedge core_clk) begin
      if (!rst_b) begin
         divCnt_q <= 8'h00;
         active_q <= 1'b0;
         bitCnt_q <= 6'h00;
         shift_q <= 64'h0000_0000_0000_0000;
         rd_q <= 1'b0;
         mdc <= 1'b0;
         mdioOut <= 1'b1;
         mdioOe <= 1'b0;
         done <= 1'b0;
         rdData <= 16'h0000;
      end else if (clkEn) begin
         done <= 1'b0;
         if (!active_q) begin
            if (start) begin
               // first preamble bit goes out at once, the rest
               // (start 01, opcode, addresses, ta, data) queue up
               active_q <= 1'b1;
               rd_q <= isRead;
               bitCnt_q <= 6'h00;
               divCnt_q <= 8'h00;
               mdioOut <= 1'b1;
               mdioOe <= 1'b1;
               shift_q <= {31'h7fff_ffff, 2'b01,
                  isRead ? 2'b10 : 2'b01, phyAddr, regAddr,
                  2'b10, isRead ? 16'h0000 : wrData, 1'b0};
            end
         end else if (divCnt_q == (`SMPA_MDC_HALF_CYC - 1)) begin
            divCnt_q <= 8'h00;
            mdc <= ~mdc;
            if (!mdc) begin
               // mdc rises: phy samples the line, we sample read data
               if (rd_q && bitCnt_q >= `SMPA_DATA_BIT)
                  rdData <= {rdData[14:0], mdioInSync};
            end else if ({1'b0, bitCnt_q} == `SMPA_FRAME_BITS - 7'd1) begin
               // mdc falls after the last bit: release and report
               active_q <= 1'b0;
               mdioOut <= 1'b1;
               mdioOe <= 1'b0;
               done <= 1'b1;
               bitCnt_q <= 6'h00;
            end else begin
               // mdc falls: next bit, line handed to phy from ta on in read frames
               mdioOut <= shift_q[63];
               mdioOe <= !(rd_q && bitCnt_q >= `SMPA_TA_BIT - 6'd1);
               shift_q <= {shift_q[62:0], 1'b0};
               bitCnt_q <= bitCnt_q + 6'd1;
            end
         end else begin
            divCnt_q <= divCnt_q + 8'h01;
         end
      end
   end
endmodule
`default_nettype wire

//--- smpa_access_assertions.sv
// Purpose: port checks for smpa_access
// Assumes: clkEn is held high by the bench
// Notes: bound to every smpa_access instance
`timescale 1ns/1ns
`default_nettype none
module smpa_access_assertions (
   input wire logic core_clk, // clock
   input wire logic rst_b, // sync reset, low
   input wire logic clkEn, // clock enable
   input wire logic psel, // apb select
   input wire logic penable, // apb enable
   input wire logic pwrite, // apb direction
   input wire logic [7:0] paddr, // apb address
   input wire logic [31:0] pwdata, // apb write data
   input wire logic [31:0] prdata, // apb read data
   input wire logic pready, // apb ready
   input wire logic pslverr, // apb error
   input wire logic mdioOut, // mdio drive value
   input wire logic mdioOe, // mdio drive enable
   input wire logic mdc // management clock
);
   default clocking dc @(posedge core_clk); endclocking
   default disable iff (!rst_b);
   ////////////////////////////////////////
   // offsets that answer without error
   wire logic mapped = paddr == 8'h2c || paddr == 8'h34 ||
      paddr == 8'h40 || paddr == 8'h44 || paddr == 8'h48 || paddr == 8'h4c;
   apb_answer_a:
      assert property (psel && !penable && clkEn |=> pready)
      else $error("no ready after setup");
   ready_pulse_a:
      assert property (pready |=> !pready) else $error("ready too long");
   unmapped_err_a:
      assert property (pready |-> pslverr == !mapped)
      else $error("error flag wrong");
   err_zero_a:
      assert property (pready && pslverr |-> prdata == 32'h0000_0000)
      else $error("error read not zero");
   cmd_result_a:
      assert property (pready && !pwrite && paddr == 8'h4c |->
         prdata[2:0] == 3'b000) else $error("result code not ok");
   phy_launch_a:
      assert property (pready && pwrite && paddr == 8'h2c && pwdata[27]
         |-> ##[1:100] mdioOe) else $error("no mdio frame");
   preamble_one_a:
      assert property ($rose(mdioOe) |-> mdioOut)
      else $error("frame not opened by one");
   mdc_hold_a:
      assert property ($changed(mdc) |=> $stable(mdc) [*8])
      else $error("mdc half period short");
   reset_quiet_a:
      assert property ($rose(rst_b) |-> !pready && !mdioOe && !mdc)
      else $error("outputs active after reset");
endmodule
bind smpa_access smpa_access_assertions u_chk (.core_clk(core_clk),
   .rst_b(rst_b), .clkEn(clkEn), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
   .pready(pready), .pslverr(pslverr), .mdioOut(mdioOut),
   .mdioOe(mdioOe), .mdc(mdc));
`default_nettype wire

//--- smpa_phy_model.sv
// Purpose: phy register file behind the mdio line
// Assumes: line pulled up when nobody drives
// Notes: frame start is 14 ones, a zero, then a one
`timescale 1ns/1ns
`default_nettype none
module smpa_phy_model (
   input wire logic mdc, // management clock
   input wire logic mdio, // resolved line
   output logic phyOut = 1'b1, // drive value
   output logic phyOe = 1'b0 // drive enable
);
   logic [4:0] n = 5'h00; // bit position, 0 = idle
   logic [14:0] sr; // sampled bits
   logic rd = 1'b0; // frame is a read
   logic [9:0] adr; // {port, register}
   logic [15:0] mem [0:1023]; // phy registers
   ////////////////////////////////////////
   // sample on rising mdc
   always @(posedge mdc) begin
      sr <= {sr[13:0], mdio};
      if (n != 5'h00)
         n <= n + 5'h01;
      else if (sr == 15'h7ffe && mdio)
         n <= 5'h02;
      if (n == 5'h0d) begin // header done
         rd <= sr[10:9] == 2'b10;
         adr <= {sr[8:0], mdio};
      end
      if (n == 5'h1f && !rd) // store write data
         mem[adr] <= {sr[14:0], mdio};
   end
   // drive turnaround zero and read data on falling mdc
   always @(negedge mdc) begin
      phyOe <= rd && n >= 5'h0f;
      phyOut <= (n == 5'h0f) ? 1'b0 : mem[adr][5'h1f - n];
   end
endmodule
`default_nettype wire

//--- tb.sv
// Purpose: self-checking bench for smpa_access
// Assumes: apb master, phy model on mdio
// Notes: clkEn tied high
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin mismatches++; \
   $display("Error at %0t got %h exp %h", $time, (a), (e)); end end
module tb;
   logic core_clk = 1'b0, rst_b = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, pready, pslverr, rerr, mdioOut, mdioOe, mdc;
   logic phyOut, phyOe;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, prdata, rdat;
   logic [8:0] straps = 9'h000; // strap pins
   logic [4:0] ix [0:2] = '{5'h00, 5'h01, 5'h1f}; // table indexes
   // port maps stored at those indexes, port 25 always set
   logic [25:0] pm [0:2] = '{26'h200_0006, 26'h200_1117, 26'h200_2228};
   integer mismatches = 0, n_checks = 0, i;
   // pulled-up mdio line
   wire logic mdio = mdioOe ? mdioOut : (phyOe ? phyOut : 1'b1);
   smpa_access u_smpa_access (.core_clk(core_clk), .rst_b(rst_b),
      .clkEn(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .agingDisPin(straps[0]), .autoNegPin(straps[1]),
      .backPressPin(straps[2]), .flowCtrlPin(straps[3]),
      .interPacketGapPin(straps[4]), .trunkPin(straps[5]),
      .rmiiSelPin(straps[7:6]), .bondRmiiPin(straps[8]), .mdioIn(mdio),
      .mdioOut(mdioOut), .mdioOe(mdioOe), .mdc(mdc));
   smpa_phy_model u_smpa_phy_model (.mdc(mdc), .mdio(mdio),
      .phyOut(phyOut), .phyOe(phyOe));
   initial forever #4 core_clk = ~core_clk;
   ////////////////////////////////////////
   // one apb transfer, result in rdat and rerr
   task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
      integer k;
      @(posedge core_clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge core_clk);
      penable <= 1'b1;
      k = 0;
      do begin @(posedge core_clk); k++; end
      while (pready !== 1'b1 && k < 20);
      if (k >= 20) mismatches++;
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   // poll a busy bit until clear
   task automatic pollClear(input logic [7:0] a, input integer b);
      integer k;
      k = 0;
      do begin apb(1'b0, a, 32'h0000_0000); k++; end
      while (rdat[b] !== 1'b0 && k < 3000);
      `CHK(rdat[b], 1'b0)
   endtask
   task tStrap;
      for (i = 0; i < 11; i++) begin
         straps <= (i == 9) ? 9'h1ff : 9'h001 << i;
         repeat (4) @(posedge core_clk);
         apb(1'b0, 8'h34, 32'h0000_0000);
         `CHK(rdat[2:0], straps[2:0])
         `CHK(rdat[5:3], straps[5:3])
         `CHK(rdat[8:6], straps[8:6])
      end
   endtask
   task tTable;
      for (i = 0; i < 3; i++) begin
         pollClear(8'h4c, 3);
         apb(1'b1, 8'h40, {1'b0, ix[i], pm[i]});
         apb(1'b1, 8'h44, 32'h0000_0004);
      end
      pollClear(8'h4c, 3);
      apb(1'b1, 8'h40, {1'b0, 5'h01, 26'h000_0000});
      apb(1'b1, 8'h44, 32'h0000_0003); // unknown code, no action
      for (i = 0; i < 3; i++) begin
         pollClear(8'h4c, 3);
         apb(1'b1, 8'h40, {1'b0, ix[i], 26'h000_0000});
         apb(1'b1, 8'h44, 32'h0000_0005);
         pollClear(8'h4c, 3);
         `CHK(rdat[2:0], 3'b000)
         apb(1'b0, 8'h48, 32'h0000_0000);
         `CHK(rdat[25:0], pm[i])
      end
   endtask
   task tPhy;
      apb(1'b0, 8'h2c, 32'h0000_0000);
      `CHK(rdat, 32'h0000_0000)
      apb(1'b1, 8'h2c, {4'h0, 1'b1, 1'b0, 5'h03, 5'h05, 16'ha5c3});
      apb(1'b1, 8'h2c, {4'h0, 1'b1, 1'b0, 5'h03, 5'h05, 16'h0f0f});
      pollClear(8'h2c, 27);
      `CHK(rdat[15:0], 16'ha5c3)
      `CHK(u_smpa_phy_model.mem[10'h065], 16'ha5c3)
      apb(1'b1, 8'h2c, {4'h0, 1'b1, 1'b1, 5'h03, 5'h05, 16'h0000});
      pollClear(8'h2c, 27);
      `CHK(rdat[15:0], 16'ha5c3)
   endtask
   task tBad;
      apb(1'b0, 8'h00, 32'h0000_0000);
      `CHK({rerr, rdat}, {1'b1, 32'h0000_0000})
      apb(1'b1, 8'h38, 32'hffff_ffff);
      `CHK(rerr, 1'b1)
   endtask
   task conclude;
      if (mismatches == 0 && n_checks > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   initial begin
      repeat (6) @(posedge core_clk);
      rst_b <= 1'b1;
      tStrap;
      tTable;
      tPhy;
      tBad;
      conclude;
   end
   // watchdog
   initial begin
      repeat (60000) @(posedge core_clk);
      mismatches++;
      conclude;
   end
endmodule
`default_nettype wire
